/* logic/amr_consts.vh */
// Behaviour
// - Bit 7 of the range register picks bus speed, one for high speed and zero for fast, reset one.
// - Bit 6 of the range register makes both interrupt outputs active low at zero (reset) or high at one.
// - Range bits 1:0 pick full scale, 01 for 10 g at reset, 10 for 20 g, 11 for 40 g.
// - The ready mask bit 2 of power control holds the sample ready pin low.
// - Bit 1 of power control or the standby bit turns temperature processing off.
// - Power control bit 0 at one (reset) is standby and stops the datapaths in low power; zero measures.
// - In standby the digital functions, FIFO pointers among them, are held in reset.
// - Self-test bit 0 enables self-test mode and resets to zero.
// - Self-test bit 1 applies the self-test force and resets to zero.
// - Writing 0x52 to the write-only reset register resets the device like power-on.
// - After power-on and each software reset, factory values load into shadow registers.
// - Outside standby, each enabled interrupt source drives its output with the chosen polarity.
`ifndef AMR_CONSTS_VH
`define AMR_CONSTS_VH
`define AMR_ADDR_RANGE 8'h2C
`define AMR_ADDR_POWER 8'h2D
`define AMR_ADDR_SELFTEST 8'h2E
`define AMR_ADDR_RESET 8'h2F
`define AMR_ADDR_SHADOW_LO 8'h50
`define AMR_ADDR_SHADOW_HI 8'h54
`define AMR_RANGE_RESET 8'h81
`define AMR_POWER_RESET 8'h01
`define AMR_SELFTEST_RESET 8'h00
`define AMR_RANGE_MASK 8'hC3
`define AMR_POWER_MASK 8'h07
`define AMR_SELFTEST_MASK 8'h03
`define AMR_RESET_CODE 8'h52
`define AMR_BIT_SPEED 7
`define AMR_BIT_POL 6
`define AMR_BIT_MASK_RDY 2
`define AMR_BIT_TEMP_OFF 1
`define AMR_BIT_STANDBY 0
`define AMR_BIT_ST_MODE 0
`define AMR_BIT_ST_FORCE 1
`define AMR_SHADOW_COUNT 5
`define AMR_SHADOW_IDX_W 3
`endif

/* logic/amr_shadow_load.v */
`timescale 1ns/1ps
// copies factory store words into shadow flip-flops after any reset
module amr_shadow_load (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // factory store read port
  output reg [2:0] store_addr,
  input wire [7:0] store_data,
  // shadow access
  input wire [2:0] rd_idx,
  output wire [7:0] rd_data,
  output reg loading
);
`include "amr_consts.vh"
  reg [7:0] shadow [0:4];
  reg [2:0] fill_idx;
  reg pending;

  assign rd_data = (rd_idx < `AMR_SHADOW_COUNT) ? shadow[rd_idx] : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // store address held two cycles, data latched on the second edge
  // reload shadow values
  always @(posedge core_clk) begin
    if (rst) begin
      store_addr <= 3'h0;
      fill_idx <= 3'h0;
      pending <= 1'b0;
      loading <= 1'b1;
    end else if (loading) begin
      // two cycles per word: store answers one edge after the address
      pending <= ~pending;
      if (pending) begin
        shadow[fill_idx] <= store_data;
        fill_idx <= fill_idx + 3'h1;
        if (fill_idx == `AMR_SHADOW_COUNT - 1) begin
          loading <= 1'b0;
          pending <= 1'b0;
        end else begin
          store_addr <= store_addr + 3'h1;
        end
      end
    end
  end
endmodule // amr_shadow_load

/* logic/amr_regs.v */
`timescale 1ns/1ps
module amr_regs (
  // clock and power-on reset
  input wire core_clk,
  input wire rst,
  // register port from the serial interface
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output reg reg_rvalid,
  // factory store
  output wire [2:0] factory_store_addr,
  input wire [7:0] factory_store_data,
  // interrupt sources and map
  input wire [7:0] irq_map,
  input wire [3:0] irq_src,
  input wire sample_ready_raw,
  // pins and controls
  output reg irq_out_a,
  output reg irq_out_b,
  output reg sample_ready_pin,
  output reg bus_speed_select,
  output reg irq_polarity,
  output reg [1:0] range_sel,
  output reg temp_enable,
  output reg datapath_enable,
  output reg low_power,
  output reg digital_reset,
  output reg selftest_mode_bit,
  output reg selftest_force_bit,
  output reg shadow_loading
);
`include "amr_consts.vh"
  reg [7:0] range_reg;
  reg [7:0] power_reg;
  reg [7:0] selftest_reg;
  reg soft_rst;
  reg [3:0] src_s1;
  reg [3:0] src_s2;
  reg rdy_s1;
  reg rdy_s2;
  wire dev_rst;
  wire [7:0] shadow_data;
  wire loading;
  wire standby;
  wire any_a;
  wire any_b;

  function [7:0] masked_write;
    input [7:0] data;
    input [7:0] mask;
    begin
      masked_write = data & mask;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // software reset acts as power-on
  assign dev_rst = rst | soft_rst;
  assign standby = power_reg[`AMR_BIT_STANDBY];

  amr_shadow_load u_shadow (
    .core_clk(core_clk),
    .rst(dev_rst),
    .store_addr(factory_store_addr),
    .store_data(factory_store_data),
    .rd_idx(reg_addr[2:0]),
    .rd_data(shadow_data),
    .loading(loading)
  );

  ////////////////////////////////////////////////////////////////////////
  // register writes
  always @(posedge core_clk) begin
    if (dev_rst) begin
      range_reg <= `AMR_RANGE_RESET;
      power_reg <= `AMR_POWER_RESET;
      selftest_reg <= `AMR_SELFTEST_RESET;
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= 1'b0;
      if (reg_wr) begin
        case (reg_addr)
          `AMR_ADDR_RANGE: begin
            range_reg <= masked_write(reg_wdata, `AMR_RANGE_MASK);
          end
          `AMR_ADDR_POWER: begin
            power_reg <= masked_write(reg_wdata, `AMR_POWER_MASK);
          end
          `AMR_ADDR_SELFTEST: begin
            selftest_reg <= masked_write(reg_wdata, `AMR_SELFTEST_MASK);
          end
          `AMR_ADDR_RESET: begin
            soft_rst <= (reg_wdata == `AMR_RESET_CODE);
          end
          default: begin
            soft_rst <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register reads, one cycle latency
  always @(posedge core_clk) begin
    if (dev_rst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `AMR_ADDR_RANGE: reg_rdata <= range_reg;
          `AMR_ADDR_POWER: reg_rdata <= power_reg;
          `AMR_ADDR_SELFTEST: reg_rdata <= selftest_reg;
          `AMR_ADDR_RESET: reg_rdata <= 8'h00;
          default: begin
            if (reg_addr >= `AMR_ADDR_SHADOW_LO && reg_addr <= `AMR_ADDR_SHADOW_HI) begin
              reg_rdata <= shadow_data;
            end else begin
              reg_rdata <= 8'h00;
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // source synchronisers
  always @(posedge core_clk) begin
    if (rst) begin
      src_s1 <= 4'h0;
      src_s2 <= 4'h0;
      rdy_s1 <= 1'b0;
      rdy_s2 <= 1'b0;
    end else begin
      src_s1 <= irq_src;
      src_s2 <= src_s1;
      rdy_s1 <= sample_ready_raw;
      rdy_s2 <= rdy_s1;
    end
  end

  assign any_a = |(src_s2 & irq_map[3:0]);
  assign any_b = |(src_s2 & irq_map[7:4]);

  ////////////////////////////////////////////////////////////////////////
  // control and pin outputs
  always @(posedge core_clk) begin
    if (dev_rst) begin
      irq_out_a <= 1'b1;
      irq_out_b <= 1'b1;
      sample_ready_pin <= 1'b0;
      bus_speed_select <= 1'b1;
      irq_polarity <= 1'b0;
      range_sel <= 2'h1;
      temp_enable <= 1'b0;
      datapath_enable <= 1'b0;
      low_power <= 1'b1;
      digital_reset <= 1'b1;
      selftest_mode_bit <= 1'b0;
      selftest_force_bit <= 1'b0;
      shadow_loading <= 1'b1;
    end else begin
      irq_out_a <= (any_a & ~standby) ^ ~range_reg[`AMR_BIT_POL];
      irq_out_b <= (any_b & ~standby) ^ ~range_reg[`AMR_BIT_POL];
      sample_ready_pin <= rdy_s2 & ~standby & ~power_reg[`AMR_BIT_MASK_RDY];
      bus_speed_select <= range_reg[`AMR_BIT_SPEED];
      irq_polarity <= range_reg[`AMR_BIT_POL];
      range_sel <= range_reg[1:0];
      temp_enable <= ~power_reg[`AMR_BIT_TEMP_OFF] & ~standby & ~loading;
      datapath_enable <= ~standby & ~loading;
      low_power <= standby;
      digital_reset <= standby | loading;
      selftest_mode_bit <= selftest_reg[`AMR_BIT_ST_MODE];
      selftest_force_bit <= selftest_reg[`AMR_BIT_ST_FORCE];
      shadow_loading <= loading;
    end
  end
endmodule // amr_regs

/* verification/amr_regs_monitor.sv */
`timescale 1ns/1ps
module amr_regs_monitor (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // register port
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  // controls
  input wire sample_ready_pin,
  input wire bus_speed_select,
  input wire irq_polarity,
  input wire [1:0] range_sel,
  input wire temp_enable,
  input wire datapath_enable,
  input wire digital_reset,
  input wire selftest_mode_bit,
  input wire selftest_force_bit,
  input wire shadow_loading
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire w2c = reg_wr && reg_addr == 8'h2C;
  wire w2d = reg_wr && reg_addr == 8'h2D;
  spd_pol_copy_a: assert property (
    w2c |-> ##2 {bus_speed_select, irq_polarity} == $past(reg_wdata[7:6], 2)) else $error("speed");
  range_copy_a: assert property (
    w2c |-> ##2 range_sel == $past(reg_wdata[1:0], 2)) else $error("range");
  ready_mask_a: assert property (
    w2d && reg_wdata[2] |-> ##3 !sample_ready_pin [*2]) else $error("ready mask");
  temp_off_a: assert property (
    w2d && reg_wdata[1:0] != 2'h0 |-> ##2 !temp_enable [*3]) else $error("temp");
  standby_mode_a: assert property (
    w2d |-> ##2 datapath_enable != $past(reg_wdata[0], 2)) else $error("standby");
  held_reset_a: assert property (
    !datapath_enable |-> digital_reset) else $error("digital reset");
  selftest_copy_a: assert property (
    reg_wr && reg_addr == 8'h2E |-> ##2
    {selftest_force_bit, selftest_mode_bit} == $past(reg_wdata[1:0], 2)) else $error("selftest");
  soft_reset_a: assert property (
    reg_wr && reg_addr == 8'h2F && reg_wdata == 8'h52 |-> ##[2:3]
    shadow_loading && range_sel == 2'h1 && bus_speed_select) else $error("soft reset");
  reset_reg_zero_a: assert property (
    reg_rd && reg_addr == 8'h2F |-> ##2 reg_rdata == 8'h00) else $error("reset reg read");
  reserved_zero_a: assert property (
    reg_rd && reg_addr == 8'h2C |-> ##2 reg_rdata[5:2] == 4'h0) else $error("reserved bits");
endmodule // amr_regs_monitor
bind amr_regs amr_regs_monitor i_amr_regs_monitor (.core_clk(core_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .sample_ready_pin(sample_ready_pin),
  .bus_speed_select(bus_speed_select), .irq_polarity(irq_polarity), .range_sel(range_sel),
  .temp_enable(temp_enable), .datapath_enable(datapath_enable), .digital_reset(digital_reset),
  .selftest_mode_bit(selftest_mode_bit), .selftest_force_bit(selftest_force_bit),
  .shadow_loading(shadow_loading));

/* verification/amr_store_model.sv */
`timescale 1ns/1ps
module amr_store_model (
  // clock
  input wire core_clk,
  // read port
  input wire [2:0] store_addr,
  output reg [7:0] store_data
);
  always @(posedge core_clk) begin
    store_data <= 8'hA0 + {5'h00, store_addr};
  end
endmodule // amr_store_model

/* verification/amr_regs_tb.sv */
`timescale 1ns/1ps
module amr_regs_tb;
  reg core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, sample_ready_raw = 1;
  reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, irq_map = 8'h11, i;
  reg [3:0] irq_src = 4'h1;
  wire [7:0] reg_rdata, store_data;
  wire [2:0] store_addr;
  wire [1:0] range_sel;
  wire reg_rvalid, irq_out_a, irq_out_b, sample_ready_pin, bus_speed_select, irq_polarity;
  wire temp_enable, datapath_enable, low_power, digital_reset, selftest_mode_bit;
  wire selftest_force_bit, shadow_loading;
  wire [7:0] ctl = {bus_speed_select, irq_polarity, temp_enable, datapath_enable, low_power,
    digital_reset, range_sel};
  wire [7:0] pin = {2'h0, irq_out_b, selftest_force_bit, selftest_mode_bit, irq_out_a,
    sample_ready_pin, shadow_loading};
  integer error_cnt = 0, num_checks = 0;
  always #2 core_clk = ~core_clk;
  amr_regs i_amr_regs (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .factory_store_addr(store_addr), .factory_store_data(store_data), .irq_map(irq_map),
    .irq_src(irq_src), .sample_ready_raw(sample_ready_raw), .irq_out_a(irq_out_a),
    .irq_out_b(irq_out_b), .sample_ready_pin(sample_ready_pin),
    .bus_speed_select(bus_speed_select), .irq_polarity(irq_polarity), .range_sel(range_sel),
    .temp_enable(temp_enable), .datapath_enable(datapath_enable), .low_power(low_power),
    .digital_reset(digital_reset), .selftest_mode_bit(selftest_mode_bit),
    .selftest_force_bit(selftest_force_bit), .shadow_loading(shadow_loading));
  amr_store_model i_amr_store_model (.core_clk(core_clk), .store_addr(store_addr),
    .store_data(store_data));
  task chk(input string n, input [7:0] e, input [7:0] g);
    num_checks = num_checks + 1;
    if (g !== e) begin
      error_cnt = error_cnt + 1;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge core_clk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(posedge core_clk) #1;
    reg_wr = 0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    @(posedge core_clk) #1;
    reg_addr = a;
    reg_rd = 1;
    @(posedge core_clk) #1;
    reg_rd = 0;
    chk("rvalid", 8'h01, {7'h00, reg_rvalid});
    chk("rdata", e, reg_rdata);
  endtask
  task settle;
    repeat (5) @(posedge core_clk);
    #1;
  endtask
  task summarize;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #20000;
    error_cnt = error_cnt + 1;
    summarize;
  end
  initial begin
    repeat (8) @(posedge core_clk);
    #1;
    rst = 0;
    settle;
    settle;
    settle;
    chk("ctl", 8'h8D, ctl);
    chk("pins", 8'h24, pin);
    rd(8'h2C, 8'h81);
    rd(8'h2D, 8'h01);
    rd(8'h2E, 8'h00);
    rd(8'h2F, 8'h00);
    for (i = 0; i < 5; i = i + 1) rd(8'h50 + i, 8'hA0 + i);
    for (i = 1; i < 4; i = i + 1) begin
      wr(8'h2C, 8'h7C | i);
      rd(8'h2C, 8'h40 | i);
    end
    chk("ctl", 8'h4F, ctl);
    wr(8'h2E, 8'hFF);
    rd(8'h2E, 8'h03);
    wr(8'h2F, 8'h51);
    rd(8'h2C, 8'h43);
    wr(8'h2D, 8'hF8);
    settle;
    chk("ctl", 8'h73, ctl);
    chk("pins", 8'h3E, pin);
    rd(8'h2D, 8'h00);
    wr(8'h2D, 8'h06);
    settle;
    chk("ctl", 8'h53, ctl);
    chk("pins", 8'h3C, pin);
    wr(8'h2D, 8'h01);
    wr(8'h2C, 8'h01);
    wr(8'h2D, 8'h00);
    settle;
    chk("pins", 8'h1A, pin);
    wr(8'h2D, 8'h01);
    wr(8'h2F, 8'h52);
    settle;
    settle;
    settle;
    chk("ctl", 8'h8D, ctl);
    chk("pins", 8'h24, pin);
    for (i = 0; i < 5; i = i + 1) rd(8'h50 + i, 8'hA0 + i);
    summarize;
  end
endmodule // amr_regs_tb
